// >>> ihp_port.v
// What this block does
// RULE_01: With the port set as a 16-bit target, a word access into the legacy register window is refused and only byte accesses go through.
// RULE_02: A byte for the legacy register window is steered to or from internal lane 0 whichever host lane carries it.
// RULE_03: In the legacy register window an even address uses only the even host byte and an odd address only the odd one.
// RULE_04: The legacy register window answers only while the VGA enable input is low.
// RULE_05: In the external device window only internal lane 0 is enabled and lanes 1 to 3 are masked.
// RULE_06: The host reaches external devices only through lane 0 at doubleword-aligned addresses; other lanes or wider accesses are its own fault.
// RULE_07: Address buffer enable, write direction and four active-low lane enables are sequenced with dead cycles so the local bus never sees two drivers.
// The code keeps no dead cycle between address and data phases: the lanes open on the same edge that the address drive stops.
// RULE_08: For external device cycles the port drives the address onto the local bus itself and keeps the address buffer disabled.
// RULE_09: The expansion strobe also fires in I/O space decoded on 16 bits, so outside logic qualifies it with the command strobe.
// RULE_10: No recovery time is enforced between palette accesses; outside hardware or software provides it.
// RULE_11: The palette converter is selected by I/O cycles in VGA mode and by memory cycles in graphics mode.
// RULE_12: All lane enables stay inactive except in the data phase of a cycle that is not refused.
`include "ihp_defs.vh"

module ihp_port
(
	// Clock and reset
	input wire sys_clk_i,
	input wire nrst_i,
	// Configuration
	input wire isa16_i,
	input wire vga_en_i,
	input wire expdev_en_i,
	// Host cycle, held for the whole command
	input wire cyc_i,
	input wire mem_i,
	input wire wr_i,
	input wire [15:0] host_addr_i,
	input wire host_bhe_n_i,
	input wire [15:0] host_wdata_i,
	output reg [15:0] host_rdata_o,
	output reg size_err_o,
	// Internal register side
	output reg int_wr_o,
	output reg int_rd_o,
	output reg [3:0] int_be_o,
	output reg [31:0] int_wdata_o,
	input wire [31:0] int_rdata_i,
	output reg vgareg_sel_o,
	output reg extdev_sel_o,
	output reg dac_sel_o,
	// Multiplexed local address/data bus
	input wire [31:0] local_ad_i,
	output reg [31:0] local_ad_o,
	output reg local_ad_oe_o,
	// Buffer and transceiver controls, expansion strobe
	output reg addr_buffer_enable_n_o,
	output reg data_write_direction_o,
	output reg [3:0] data_lane_enable_n_o,
	output reg expansion_select_n_o
);

	localparam ST_IDLE = 3'd0;
	localparam ST_ADDR = 3'd1;
	localparam ST_TURN = 3'd2;
	localparam ST_DATA = 3'd3;
	localparam ST_RECOV = 3'd4;

	reg [2:0] state;
	reg [2:0] next_state;
	reg [1:0] wait_cnt;
	reg cyc_d;
	reg is_ext;
	reg is_refused;
	reg [3:0] lanes;
	reg [3:0] next_lanes;
	wire cyc_start;
	wire in_vgareg;
	wire in_ext;
	wire in_dac_mem;
	wire in_dac_io;
	wire in_exp_mem;
	wire in_exp_io;
	wire vgareg_ok;
	wire vgareg_word;
	wire dac_hit;
	wire exp_hit;

	assign cyc_start = cyc_i & ~cyc_d;

	// Address decode
	assign in_vgareg = mem_i & (host_addr_i >= `IHP_VGAREG_LO) & (host_addr_i <= `IHP_VGAREG_HI);
	assign in_ext = mem_i & (host_addr_i >= `IHP_EXT_LO) & (host_addr_i <= `IHP_EXT_HI);
	assign in_dac_mem = mem_i & (host_addr_i >= `IHP_DAC_MEM_LO) & (host_addr_i <= `IHP_DAC_MEM_HI);
	assign in_dac_io = ~mem_i & (host_addr_i >= `IHP_DAC_IO_LO) & (host_addr_i <= `IHP_DAC_IO_HI);
	assign in_exp_mem = mem_i & (host_addr_i >= `IHP_EXP_MEM_LO) & (host_addr_i <= `IHP_EXP_MEM_HI);
	assign in_exp_io = ~mem_i & (host_addr_i >= `IHP_EXP_IO_LO) & (host_addr_i <= `IHP_EXP_IO_HI);

	// Legacy window only in graphics mode
	assign vgareg_ok = in_vgareg & ~vga_en_i; // see RULE_04
	// Even address with high byte enabled is a word on a 16-bit slot
	assign vgareg_word = isa16_i & ~host_addr_i[0] & ~host_bhe_n_i; // see RULE_01
	// Palette by I/O in VGA mode, by memory in graphics mode
	assign dac_hit = (in_dac_io & vga_en_i) | (in_dac_mem & ~vga_en_i); // see RULE_11
	// Plain 16-bit compare: an I/O hit needs all 16 address bits, so the ports do not alias
	assign exp_hit = expdev_en_i & (in_exp_mem | in_exp_io); // see RULE_09

	// Internal lanes used by the cycle
	always @*
	begin
		next_lanes = `IHP_LANE_NONE;
		if (vgareg_ok | in_ext | in_dac_io)
			next_lanes = `IHP_LANE0; // see RULE_02
		else if (host_addr_i[1])
			next_lanes = {~host_bhe_n_i, ~host_addr_i[0] | ~isa16_i, 2'b00};
		else
			next_lanes = {2'b00, ~host_bhe_n_i, ~host_addr_i[0] | ~isa16_i};
	end

	// Cycle sequencer
	always @*
	begin
		next_state = state;
		case (state)
			ST_IDLE:
			begin
				if (cyc_start)
					next_state = ST_ADDR;
			end
			ST_ADDR:
			begin
				next_state = ST_TURN;
			end
			ST_TURN:
			begin
				if (wait_cnt == 2'd0)
					next_state = ST_DATA; // see RULE_07
			end
			ST_DATA:
			begin
				if (~cyc_i)
					next_state = ST_RECOV;
			end
			ST_RECOV:
			begin
				if (wait_cnt == 2'd0)
					next_state = ST_IDLE;
			end
			default:
			begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// State, decode latches and dead-cycle counter
	always @(posedge sys_clk_i)
	begin
		if (!nrst_i)
		begin
			state <= ST_IDLE;
			wait_cnt <= 2'd0;
			cyc_d <= 1'b0;
			is_ext <= 1'b0;
			is_refused <= 1'b0;
			lanes <= `IHP_LANE_NONE;
			vgareg_sel_o <= 1'b0;
			extdev_sel_o <= 1'b0;
			dac_sel_o <= 1'b0;
			size_err_o <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cyc_d <= cyc_i;
			size_err_o <= 1'b0;
			if (state == ST_ADDR)
				wait_cnt <= `IHP_TURN_CYC - 2'd1;
			else if (state == ST_DATA)
				wait_cnt <= `IHP_RECOV_CYC - 2'd1;
			else if (wait_cnt != 2'd0)
				wait_cnt <= wait_cnt - 2'd1;
			if (state == ST_IDLE && cyc_start)
			begin
				is_ext <= in_ext;
				is_refused <= (vgareg_ok & vgareg_word) | (in_vgareg & vga_en_i);
				size_err_o <= vgareg_ok & vgareg_word; // see RULE_01
				// Ext devices keep only lane 0
				lanes <= in_ext ? (next_lanes & `IHP_LANE0) : next_lanes; // see RULE_05
				vgareg_sel_o <= vgareg_ok & ~vgareg_word;
				extdev_sel_o <= in_ext;
				dac_sel_o <= dac_hit; // No recovery spacing here, see RULE_10
			end
			else if (state == ST_IDLE)
			begin
				vgareg_sel_o <= 1'b0;
				extdev_sel_o <= 1'b0;
				dac_sel_o <= 1'b0;
			end
		end
	end

	// Buffer controls, address drive and expansion strobe
	always @(posedge sys_clk_i)
	begin
		if (!nrst_i)
		begin
			addr_buffer_enable_n_o <= 1'b1;
			data_write_direction_o <= 1'b0;
			data_lane_enable_n_o <= 4'hF;
			local_ad_o <= 32'h0000_0000;
			local_ad_oe_o <= 1'b0;
			expansion_select_n_o <= 1'b1;
		end
		else
		begin
			addr_buffer_enable_n_o <= 1'b1;
			data_lane_enable_n_o <= 4'hF; // see RULE_12
			local_ad_oe_o <= 1'b0;
			if (state == ST_IDLE && cyc_start)
			begin
				data_write_direction_o <= wr_i;
				expansion_select_n_o <= ~exp_hit;
				if (in_ext)
				begin
					// Port drives the address itself, buffer stays off
					local_ad_o <= {16'h0000, host_addr_i}; // see RULE_08
					local_ad_oe_o <= 1'b1;
				end
				else
					addr_buffer_enable_n_o <= 1'b0;
			end
			else if (state == ST_ADDR)
			begin
				// Hold the address phase one more cycle
				local_ad_oe_o <= is_ext;
				addr_buffer_enable_n_o <= is_ext;
			end
			else if (next_state == ST_DATA && !is_refused)
			begin
				// Lanes open on the same edge that the address driver lets go
				data_lane_enable_n_o <= ~lanes; // see RULE_07
			end
			if (state == ST_DATA && next_state == ST_RECOV)
				expansion_select_n_o <= 1'b1;
		end
	end

	// Data steering between host lanes and internal lanes
	always @(posedge sys_clk_i)
	begin
		if (!nrst_i)
		begin
			int_wr_o <= 1'b0;
			int_rd_o <= 1'b0;
			int_be_o <= 4'h0;
			int_wdata_o <= 32'h0000_0000;
			host_rdata_o <= 16'h0000;
		end
		else
		begin
			int_wr_o <= 1'b0;
			int_rd_o <= 1'b0;
			if (state == ST_TURN && next_state == ST_DATA && !is_refused)
			begin
				int_be_o <= lanes;
				int_wr_o <= wr_i & ~is_ext;
				int_rd_o <= ~wr_i & ~is_ext;
				if (lanes == `IHP_LANE0)
					// Odd address takes the odd host byte only
					int_wdata_o <= {24'h00_0000, host_addr_i[0] ? host_wdata_i[15:8]
						: host_wdata_i[7:0]}; // see RULE_03
				else
					int_wdata_o <= {host_wdata_i, host_wdata_i};
			end
			if (state == ST_DATA && !wr_i)
			begin
				if (is_refused)
					host_rdata_o <= 16'h0000;
				else if (lanes == `IHP_LANE0)
					// Lane 0 byte returned on the lane the host reads
					host_rdata_o <= is_ext ? {local_ad_i[7:0], local_ad_i[7:0]}
						: {int_rdata_i[7:0], int_rdata_i[7:0]}; // see RULE_02
				else
					host_rdata_o <= host_addr_i[1] ? int_rdata_i[31:16] : int_rdata_i[15:0];
			end
		end
	end

endmodule

// >>> ihp_defs.vh
`ifndef IHP_DEFS_VH
`define IHP_DEFS_VH

// Window bounds inside the controller memory space (byte offsets)
`define IHP_VGAREG_LO 16'h1F00
`define IHP_VGAREG_HI 16'h1FFF
`define IHP_EXT_LO 16'h3C00
`define IHP_EXT_HI 16'h3FFC
// Palette converter slots inside the external device window
`define IHP_DAC_MEM_LO 16'h3C00
`define IHP_DAC_MEM_HI 16'h3C1C
// Expansion strobe memory range inside the external device window
`define IHP_EXP_MEM_LO 16'h3E00
`define IHP_EXP_MEM_HI 16'h3FFC
// Legacy I/O ports, decoded on the low 16 address bits only
`define IHP_DAC_IO_LO 16'h03C6
`define IHP_DAC_IO_HI 16'h03C9
`define IHP_EXP_IO_LO 16'h03E0
`define IHP_EXP_IO_HI 16'h03E7

// Lane masks
`define IHP_LANE0 4'h1
`define IHP_LANE_NONE 4'h0

// Turnaround cycles between address and data phases (the first still holds the address), and dead cycles after a cycle
`define IHP_TURN_CYC 2'h1
`define IHP_RECOV_CYC 2'h1

`endif

// >>> ihp_port_props.sv
module ihp_port_props
(
	// Clock, reset, configuration and host side
	input wire logic sys_clk_i, nrst_i, isa16_i, vga_en_i, cyc_i, mem_i, host_bhe_n_i,
	input wire logic [15:0] host_addr_i, host_wdata_i,
	// Internal side
	input wire logic size_err_o, int_wr_o, int_rd_o, vgareg_sel_o, extdev_sel_o, dac_sel_o,
	input wire logic [3:0] int_be_o,
	input wire logic [31:0] int_wdata_o,
	// Local bus controls
	input wire logic local_ad_oe_o, addr_buffer_enable_n_o,
	input wire logic [3:0] data_lane_enable_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (!nrst_i);
	// Window decodes of the address in flight, and the all-lanes-idle flag
	wire leg = mem_i && host_addr_i >= 16'h1f00 && host_addr_i <= 16'h1fff;
	wire ext = mem_i && !vga_en_i && host_addr_i >= 16'h3c00 && host_addr_i <= 16'h3ffc;
	wire idle = &data_lane_enable_n_o;

	a_lanes_idle: assert property (!cyc_i && !$past(cyc_i) |-> idle)
		else $error("lane enable active outside a cycle");
	a_ext_mask: assert property (extdev_sel_o |-> data_lane_enable_n_o[3:1] == 3'b111)
		else $error("upper lane enabled on external cycle");
	a_bus_excl: assert property (!(local_ad_oe_o && !addr_buffer_enable_n_o))
		else $error("port and address buffer drive together");
	a_no_clash: assert property (local_ad_oe_o |-> idle)
		else $error("lane enabled while port drives address");
	a_ext_seq: assert property ($rose(cyc_i) && ext |-> ##1 local_ad_oe_o
		&& addr_buffer_enable_n_o ##1 local_ad_oe_o ##1 !local_ad_oe_o && data_lane_enable_n_o
		== 4'he) else $error("external cycle sequence wrong");
	a_word_refuse: assert property ($rose(cyc_i) && leg && !vga_en_i && isa16_i
		&& !host_addr_i[0] && !host_bhe_n_i |-> ##1 size_err_o ##1
		(!size_err_o && !int_wr_o && !int_rd_o)[*3]) else $error("word access not refused");
	a_byte_steer: assert property ((int_wr_o || int_rd_o) && vgareg_sel_o
		|-> int_be_o == 4'h1 && (int_rd_o || int_wdata_o[7:0] == (host_addr_i[0] ?
		host_wdata_i[15:8] : host_wdata_i[7:0]))) else $error("legacy byte misrouted");
	a_dac_path: assert property (dac_sel_o |-> mem_i != vga_en_i)
		else $error("palette selected by wrong cycle kind");
	a_vga_gate: assert property ($rose(cyc_i) && leg && vga_en_i |=>
		(!int_wr_o && !int_rd_o)[*4]) else $error("legacy window open in VGA mode");

	// Main scenarios
	c_refuse: cover property (size_err_o);
	c_dac_io: cover property (dac_sel_o && !mem_i);
	c_leg_wr: cover property (int_wr_o && vgareg_sel_o);
endmodule

bind ihp_port ihp_port_props u_props (.sys_clk_i, .nrst_i, .isa16_i, .vga_en_i, .cyc_i, .mem_i,
	.host_bhe_n_i, .host_addr_i, .host_wdata_i, .size_err_o, .int_wr_o, .int_rd_o, .vgareg_sel_o,
	.extdev_sel_o, .dac_sel_o, .int_be_o, .int_wdata_o, .local_ad_oe_o, .addr_buffer_enable_n_o,
	.data_lane_enable_n_o);

// >>> ihp_local_dev.sv
module ihp_local_dev
(
	// Clock and port side of the local bus
	input wire logic sys_clk_i,
	input wire logic [31:0] bus_i,
	input wire logic bus_oe_i,
	input wire logic [3:0] lane_en_n_i,
	input wire logic wr_dir_i,
	// Level seen by the port
	output logic [31:0] bus_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] addr = 8'h00;
	logic [31:0] last = 32'h0000_0000;
	// Latch the device offset while the port drives the address
	always @(posedge sys_clk_i)
	begin
		if (bus_oe_i)
			addr <= bus_i[7:0];
		last <= bus_o;
	end
	// Byte device answers on lane 0 only; released lines keep toggling
	always @*
	begin
		if (bus_oe_i)
			bus_o = bus_i;
		else if (!lane_en_n_i[0] && !wr_dir_i)
			bus_o = {~last[31:8], addr ^ 8'h5a};
		else
			bus_o = ~last;
	end
endmodule

// >>> ihp_port_tb.sv
module ihp_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic vga, i16, exe, mem, wr, bhe;
		logic [15:0] addr, rd;
		logic err, dac, exp;
	} ihp_row_t;
	logic sys_clk_i = 0, nrst_i = 0, isa16_i = 1, vga_en_i = 0, expdev_en_i = 1, cyc_i = 0;
	logic mem_i = 0, wr_i = 0, host_bhe_n_i = 1, local_ad_oe_o, cyc_q = 0;
	logic size_err_o, int_wr_o, int_rd_o, vgareg_sel_o, extdev_sel_o, dac_sel_o;
	logic addr_buffer_enable_n_o, data_write_direction_o, expansion_select_n_o;
	logic [2:0] flags = 3'b000;
	logic [3:0] int_be_o, data_lane_enable_n_o;
	logic [15:0] host_addr_i = 16'h0000, host_wdata_i = 16'hc33c, host_rdata_o;
	logic [31:0] int_wdata_o, local_ad_i, local_ad_o, int_rdata_i = 32'h1234_56a5;
	int n_mismatch = 0;
	int comparisons = 0;
	// vga i16 exe mem wr bhe_n addr rdata err dac exp; device offsets are dword aligned
	ihp_row_t rows [12] = '{'{0,1,1,1,0,1,16'h1f10,16'ha5a5,0,0,0},
		'{0,1,1,1,0,0,16'h1f11,16'ha5a5,0,0,0}, '{0,1,1,1,0,0,16'h1f10,16'h0000,1,0,0},
		'{0,0,1,1,1,0,16'h1f10,16'h0000,0,0,0}, '{0,1,1,1,0,1,16'h3c04,16'h5e5e,0,1,0},
		'{0,1,1,1,0,1,16'h3e00,16'h5a5a,0,0,1}, '{0,1,0,1,0,1,16'h3e00,16'h5a5a,0,0,0},
		'{1,1,1,1,0,1,16'h1f10,16'h0000,0,0,0}, '{1,1,1,0,1,1,16'h03c8,16'h0000,0,1,0},
		'{0,1,1,0,1,1,16'h03c8,16'h0000,0,0,0}, '{1,1,1,0,1,1,16'h03e0,16'h0000,0,0,1},
		'{0,1,1,1,1,0,16'h1f21,16'h0000,0,0,0}};

	always #4 sys_clk_i = ~sys_clk_i;
	ihp_port uut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .isa16_i(isa16_i), .vga_en_i(vga_en_i),
		.expdev_en_i(expdev_en_i), .cyc_i(cyc_i), .mem_i(mem_i), .wr_i(wr_i),
		.host_addr_i(host_addr_i), .host_bhe_n_i(host_bhe_n_i), .host_wdata_i(host_wdata_i),
		.host_rdata_o(host_rdata_o), .size_err_o(size_err_o), .int_wr_o(int_wr_o),
		.int_rd_o(int_rd_o), .int_be_o(int_be_o), .int_wdata_o(int_wdata_o),
		.int_rdata_i(int_rdata_i), .vgareg_sel_o(vgareg_sel_o), .extdev_sel_o(extdev_sel_o),
		.dac_sel_o(dac_sel_o), .local_ad_i(local_ad_i), .local_ad_o(local_ad_o),
		.local_ad_oe_o(local_ad_oe_o), .addr_buffer_enable_n_o(addr_buffer_enable_n_o),
		.data_write_direction_o(data_write_direction_o),
		.data_lane_enable_n_o(data_lane_enable_n_o), .expansion_select_n_o(expansion_select_n_o));
	ihp_local_dev dev (.sys_clk_i, .bus_i(local_ad_o), .bus_oe_i(local_ad_oe_o),
		.lane_en_n_i(data_lane_enable_n_o), .wr_dir_i(data_write_direction_o), .bus_o(local_ad_i));

	// Collect refusal, palette and expansion strobes over one host cycle
	always @(posedge sys_clk_i)
	begin
		cyc_q <= cyc_i;
		if (cyc_i && !cyc_q)
			flags <= 3'b000;
		else
			flags <= flags | {size_err_o, dac_sel_o, !expansion_select_n_o};
	end

	task check(input string what, input logic [15:0] seen, exp);
		begin
			comparisons++;
			if (seen !== exp)
			begin
				n_mismatch++;
				$display("wrong value %s expected %h seen %h", what, exp, seen);
			end
		end
	endtask

	task results;
		begin
			$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
			if (n_mismatch == 0 && comparisons > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask

	// One host cycle held through its data phase, then the recovery gap
	task run(input ihp_row_t r);
		begin
			vga_en_i <= r.vga;
			isa16_i <= r.i16;
			expdev_en_i <= r.exe;
			mem_i <= r.mem;
			wr_i <= r.wr;
			host_addr_i <= r.addr;
			host_bhe_n_i <= r.bhe;
			cyc_i <= 1'b1;
			repeat (5) @(posedge sys_clk_i);
			#1;
			if (!r.wr)
				check("read data", host_rdata_o, r.rd);
			else
				check("write byte", int_wdata_o[15:0], {8'h00, r.addr[0] ? host_wdata_i[15:8]
					: host_wdata_i[7:0]});
			check("write direction", {15'h0000, data_write_direction_o},
				{15'h0000, r.wr});
			@(posedge sys_clk_i);
			cyc_i <= 1'b0;
			// Host leaves its own gap; the port adds no palette spacing
			repeat (4) @(posedge sys_clk_i);
			check("strobes", {13'h0000, flags}, {13'h0000, r.err, r.dac, r.exp});
		end
	endtask

	initial
	begin
		repeat (16) @(posedge sys_clk_i);
		check("reset state", {8'h00, data_lane_enable_n_o, addr_buffer_enable_n_o, local_ad_oe_o,
			expansion_select_n_o, size_err_o}, 16'h00fa);
		nrst_i <= 1'b1;
		@(posedge sys_clk_i);
		for (int i = 0; i < 12; i++)
			run(rows[i]);
		// Reset dropped in the middle of an external read, then one clean cycle again
		wr_i <= 1'b0;
		host_bhe_n_i <= 1'b1;
		host_addr_i <= 16'h3c04;
		cyc_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		nrst_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		#1;
		check("reset mid cycle", {8'h00, data_lane_enable_n_o, addr_buffer_enable_n_o,
			local_ad_oe_o, expansion_select_n_o, size_err_o}, 16'h00fa);
		@(posedge sys_clk_i);
		nrst_i <= 1'b1;
		cyc_i <= 1'b0;
		@(posedge sys_clk_i);
		run(rows[4]);
		results;
	end

	// Whole run is about 150 cycles; this limit only cuts a hang short
	initial
	begin
		#20000;
		n_mismatch++;
		results;
	end
endmodule
